// [bench/lfc_ctrl_props.sv]
/* lfc_ctrl_props: checker bound to lfc_ctrl.
   assumes an APB master that holds each request until pready. */
`timescale 1ns/1ps
module lfc_ctrl_props #(
  parameter int SETTLE_CYCLES = 3
) (
  input wire logic        CLOCK,
  input wire logic        RESET_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic        SYSTEM_OFF,
  input wire logic        XTAL_READY,
  input wire logic        RC_OSC_EN,
  input wire logic        XTAL_OSC_EN,
  input wire logic        XTAL_EXTERNAL,
  input wire logic        XTAL_FULL_SWING,
  input wire logic        SYNTH_EN,
  input wire logic        FAST_CLOCK_REQ,
  input wire logic        CAL_START,
  input wire logic        SLOW_RUNNING,
  input wire logic [1:0]  SLOW_CLOCK_SEL
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  wire stop_wr = PSEL && PENABLE && PREADY && PWRITE && PWDATA[0] && PADDR == 12'h00C;

  // two cycles of off so the registered enables have landed
  AST_OFF: assert property (SYSTEM_OFF [*2] |-> !(RC_OSC_EN || XTAL_OSC_EN || SYNTH_EN || SLOW_RUNNING))
    else $error("oscillator left on in system off");
  AST_XTAL_SWITCH: assert property ($rose(SLOW_CLOCK_SEL == 2'h1) |-> XTAL_OSC_EN && $past(XTAL_READY, SETTLE_CYCLES))
    else $error("switch to crystal before it settled");
  AST_STOP: assert property (stop_wr && SLOW_RUNNING |-> ##[1:3] !SLOW_RUNNING)
    else $error("stop task did not stop the clock");
  AST_SWING: assert property (XTAL_FULL_SWING |-> XTAL_EXTERNAL)
    else $error("full swing without external");
  AST_SYNTH_REQ: assert property (SYNTH_EN && !SYSTEM_OFF |=> FAST_CLOCK_REQ)
    else $error("synth running without fast clock request");
  AST_SYNTH_SRC: assert property (SLOW_RUNNING && SLOW_CLOCK_SEL == 2'h2 |-> SYNTH_EN)
    else $error("synth source without synth enable");
  AST_RC_SRC: assert property (SLOW_RUNNING && SLOW_CLOCK_SEL == 2'h0 |-> RC_OSC_EN)
    else $error("rc source without rc enable");
  AST_CAL_RC: assert property (CAL_START |-> RC_OSC_EN)
    else $error("calibration with rc off");
  AST_CAL_REQ: assert property (CAL_START && !SYSTEM_OFF |=> !CAL_START ##[0:1] FAST_CLOCK_REQ)
    else $error("calibration without fast clock request");

  cover property ($rose(SLOW_CLOCK_SEL == 2'h1));
  cover property (CAL_START);
  cover property (SLOW_RUNNING && SYNTH_EN);
endmodule : lfc_ctrl_props

bind lfc_ctrl lfc_ctrl_props #(.SETTLE_CYCLES(SETTLE_CYCLES)) lfc_ctrl_props_i (.*);

// [bench/lfc_ctrl_tb.sv]
/* lfc_ctrl_tb: self-checking bench for the slow clock controller.
   assumes short tick and settle counts and the oscillator model. */
`timescale 1ns/1ps
module lfc_ctrl_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sys_off = 1'b0;
  logic        rc_rdy, xt_rdy, fast_rdy, cal_done;
  logic        rc_en, xt_en, xt_ext, xt_fs, syn_en, fast_req, cal_start, running;
  logic [1:0]  sel;
  logic [31:0] rdat;
  logic        rerr;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          cyc = 0;

  always #10 clk = ~clk;

  lfc_ctrl #(.CT_TICK_CYCLES(4), .SETTLE_CYCLES(3)) lfc_ctrl_i (
    .CLOCK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SYSTEM_OFF(sys_off), .RC_READY(rc_rdy), .XTAL_READY(xt_rdy),
    .FAST_CLOCK_READY(fast_rdy), .CAL_DONE(cal_done), .RC_OSC_EN(rc_en),
    .XTAL_OSC_EN(xt_en), .XTAL_EXTERNAL(xt_ext), .XTAL_FULL_SWING(xt_fs),
    .SYNTH_EN(syn_en), .FAST_CLOCK_REQ(fast_req), .CAL_START(cal_start),
    .SLOW_RUNNING(running), .SLOW_CLOCK_SEL(sel));

  lfc_osc_model #(.DLY(6)) lfc_osc_model_i (
    .clk(clk), .rst_n(rst_n), .rc_en(rc_en), .xt_en(xt_en), .fast_req(fast_req),
    .cal_start(cal_start), .rc_rdy(rc_rdy), .xt_rdy(xt_rdy), .fast_rdy(fast_rdy),
    .cal_done(cal_done));

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one transfer; idle cycle after it so no signal is set twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no local limit: only the bench timeout ends a hung transfer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic poll(input logic [11:0] a, input logic [31:0] e);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while (rdat !== e && n < 40);
    chk(rdat, e);
  endtask : poll

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      $display("[FAIL] %0t run too long", $time);
      results();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    poll(12'h518, 32'h0);
    poll(12'h52C, 32'h4);
    poll(12'h538, 32'h0);
    apb(1'b0, 12'h600, 32'h0);
    chk(rerr, 1'b1);
    $display("reset values done");
    apb(1'b1, 12'h008, 32'h1);
    poll(12'h104, 32'h1);
    poll(12'h418, 32'h0001_0000);
    apb(1'b1, 12'h104, 32'h0);
    poll(12'h104, 32'h0);
    apb(1'b1, 12'h518, 32'h2);
    poll(12'h518, 32'h0);
    apb(1'b1, 12'h010, 32'h1);
    poll(12'h10C, 32'h1);
    apb(1'b1, 12'h00C, 32'h1);
    poll(12'h414, 32'h0);
    chk({rc_en, running}, 32'h0);
    $display("rc source done");
    apb(1'b1, 12'h518, 32'h2);
    apb(1'b1, 12'h008, 32'h1);
    poll(12'h418, 32'h0001_0002);
    chk({syn_en, fast_req}, 32'h3);
    apb(1'b1, 12'h00C, 32'h1);
    poll(12'h414, 32'h0);
    chk(syn_en, 1'b0);
    $display("synth source done");
    apb(1'b1, 12'h104, 32'h0);
    apb(1'b1, 12'h518, 32'h0003_0001);
    apb(1'b1, 12'h52C, 32'h1);
    apb(1'b1, 12'h008, 32'h1);
    poll(12'h418, 32'h0001_0000);
    poll(12'h104, 32'h0);
    poll(12'h418, 32'h0001_0001);
    poll(12'h104, 32'h1);
    poll(12'h41C, 32'h0003_0001);
    chk({xt_ext, xt_fs}, 32'h3);
    sys_off <= 1'b1;
    repeat (3) @(posedge clk);
    chk({rc_en, xt_en, syn_en, running}, 32'h0);
    poll(12'h414, 32'h0);
    sys_off <= 1'b0;
    // rc is off now, so a calibrate task must be refused
    apb(1'b1, 12'h10C, 32'h0);
    apb(1'b1, 12'h010, 32'h1);
    repeat (12) @(posedge clk);
    apb(1'b0, 12'h10C, 32'h0);
    chk(rdat, 32'h0);
    $display("crystal source done");
    apb(1'b1, 12'h538, 32'h20);
    apb(1'b1, 12'h014, 32'h1);
    poll(12'h128, 32'h1);
    apb(1'b1, 12'h128, 32'h0);
    apb(1'b1, 12'h014, 32'h1);
    poll(12'h128, 32'h1);
    apb(1'b1, 12'h018, 32'h1);
    poll(12'h12C, 32'h1);
    apb(1'b1, 12'h12C, 32'h0);
    apb(1'b1, 12'h018, 32'h1);
    poll(12'h12C, 32'h1);
    poll(12'h110, 32'h0);
    apb(1'b1, 12'h538, 32'h2);
    apb(1'b1, 12'h014, 32'h1);
    apb(1'b0, 12'h110, 32'h0);
    chk(rdat, 32'h0);
    poll(12'h110, 32'h1);
    $display("calibration timer done");
    results();
  end
endmodule : lfc_ctrl_tb

// [bench/lfc_osc_model.sv]
/* lfc_osc_model: behavioural oscillators, fast clock and calibration engine.
   assumes enables and requests are registered controller outputs. */
`timescale 1ns/1ps
module lfc_osc_model #(
  parameter int DLY = 6
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic rc_en,
  input  wire logic xt_en,
  input  wire logic fast_req,
  input  wire logic cal_start,
  output logic      rc_rdy,
  output logic      xt_rdy,
  output logic      fast_rdy,
  output logic      cal_done
);
  int rc_cnt_r;
  int xt_cnt_r;
  int cal_cnt_r;
  // crystal four times slower than rc so the handover can be seen
  assign rc_rdy = rc_en && rc_cnt_r == DLY;
  assign xt_rdy = xt_en && xt_cnt_r == 4 * DLY;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rc_cnt_r <= 0;
      xt_cnt_r <= 0;
    end else begin
      rc_cnt_r <= !rc_en ? 0 : (rc_cnt_r < DLY) ? rc_cnt_r + 1 : rc_cnt_r;
      xt_cnt_r <= !xt_en ? 0 : (xt_cnt_r < 4 * DLY) ? xt_cnt_r + 1 : xt_cnt_r;
    end
  end
  // fast crystal already started by software, answers a request a cycle later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) fast_rdy <= 1'b0;
    else fast_rdy <= fast_req;
  end
  // done only with reference and rc both up; rc is never stopped meanwhile
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_cnt_r <= 0;
      cal_done  <= 1'b0;
    end else begin
      cal_cnt_r <= cal_start ? DLY : (cal_cnt_r > 0) ? cal_cnt_r - 1 : 0;
      cal_done  <= cal_cnt_r == 1 && fast_rdy && rc_rdy;
    end
  end
endmodule : lfc_osc_model

// [design/lfc_cal_timer.sv]
/*
  lfc_cal_timer: countdown calibration timer with go/halt handshakes.
  Assumes go and halt are single-cycle pulses.
*/
`timescale 1ns/1ps
module lfc_cal_timer #(
  parameter int TICK_CYCLES = lfc_pkg::CT_TICK_CYCLES,
  parameter int IV_W        = 7
) (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            go,
  input  wire logic            halt,
  input  wire logic [IV_W-1:0] interval,
  output logic                 go_ack,
  output logic                 halt_ack,
  output logic                 expired,
  output logic                 running
);
  localparam int PW = $clog2(TICK_CYCLES + 1);
  logic [PW-1:0]   pre_r;
  logic [IV_W-1:0] cnt_r;
  logic            pend_go_r;
  logic            pend_halt_r;
  logic            tick;
  logic            busy;

  assign tick = running && (pre_r == TICK_CYCLES[PW-1:0] - 1'b1);
  assign busy = pend_go_r || pend_halt_r;

  // pending flags mark tasks that still await their ack
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_go_r   <= 1'b0;
      pend_halt_r <= 1'b0;
    end else if (busy) begin
      pend_go_r   <= 1'b0;
      pend_halt_r <= 1'b0;
    end else begin
      pend_go_r   <= go;
      pend_halt_r <= halt && !go;
    end
  end

  assign go_ack   = pend_go_r;
  assign halt_ack = pend_halt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      running <= 1'b0;
      cnt_r   <= '0;
      pre_r   <= '0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (!busy && go && !running) begin
        running <= 1'b1;
        cnt_r   <= interval;
        pre_r   <= '0;
      end else if (!busy && halt && !go) begin
        running <= 1'b0;
      end else if (tick) begin
        pre_r <= '0;
        if (cnt_r == '0) begin
          running <= 1'b0;
          expired <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
      end else if (running) begin
        pre_r <= pre_r + 1'b1;
      end
    end
  end

endmodule : lfc_cal_timer

// [design/lfc_ctrl.sv]
/*
  lfc_ctrl: slow clock controller with APB register file, source sequencing,
  RC calibration request and calibration timer.
  Assumes all inputs synchronous to CLOCK; oscillators report ready levels.
*/
`timescale 1ns/1ps
// Functional notes
// - system-off forces controller and every oscillator source off.
// - crystal choice runs from RC until crystal is running, then switches.
// - with crystal, started event waits for crystal start-up completion.
// - configurable crystal settle time; software enlarges it for hot range.
// - stop task stops the slow clock and its active oscillator.
// - code 0 RC, 1 crystal, 2 synthesized; external/full-swing cleared.
// - crystal plus external accepts low swing; plus full-swing, rail-to-rail.
// - synthesized clock requests fast clock while in use.
// - RC oscillator is the default source.
// - calibrate task starts RC calibration; only with RC running.
// - calibration requests fast clock and raises done event when finished.
// - calibration timer starts on go task, stops on halt task.
// - timer loads interval, counts down, at zero expires and stops.
// - timer ignores tasks while the pending ack is raised.
// - go while running or halt while stopped acks immediately.
module lfc_ctrl #(
  parameter int CT_TICK_CYCLES = lfc_pkg::CT_TICK_CYCLES,
  parameter int SETTLE_CYCLES  = lfc_pkg::SETTLE_UNIT_CYCLES
) (
  input  wire logic        CLOCK,
  input  wire logic        RESET_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        SYSTEM_OFF,
  input  wire logic        RC_READY,
  input  wire logic        XTAL_READY,
  input  wire logic        FAST_CLOCK_READY,
  input  wire logic        CAL_DONE,
  output logic             RC_OSC_EN,
  output logic             XTAL_OSC_EN,
  output logic             XTAL_EXTERNAL,
  output logic             XTAL_FULL_SWING,
  output logic             SYNTH_EN,
  output logic             FAST_CLOCK_REQ,
  output logic             CAL_START,
  output logic             SLOW_RUNNING,
  output logic      [1:0]  SLOW_CLOCK_SEL
);
  lfc_pkg::lfc_state_t state_r;
  lfc_pkg::lfc_src_t   src_sel_r;
  lfc_pkg::lfc_src_t   src_copy_r;
  logic [3:0]  settle_r;
  logic [6:0]  ct_iv_r;
  logic        run_r;
  logic        cal_busy_r;
  logic        ev_started_r;
  logic        ev_done_r;
  logic        ev_expired_r;
  logic        ev_go_ack_r;
  logic        ev_halt_ack_r;
  logic        acc;
  logic        wr;
  logic        mapped;
  logic [31:0] rdata;
  logic        t_start;
  logic        t_stop;
  logic        t_cal;
  logic        t_go;
  logic        t_halt;
  logic        settled;
  logic        started_set;
  logic        done_set;
  logic        cal_accept;
  logic        ct_go_ack;
  logic        ct_halt_ack;
  logic        ct_expired;
  logic        ct_running;
  logic [1:0]  start_code;

  function automatic logic task_hit(input logic [11:0] off);
    task_hit = wr && (PADDR == off) && PWDATA[0];
  endfunction : task_hit

  // one wait state: PREADY rises the cycle after the access phase begins
  assign acc = PSEL && PENABLE && PREADY;
  assign wr  = acc && PWRITE;

  assign t_start = task_hit(lfc_pkg::OFF_SLOW_START_TASK);
  assign t_stop  = task_hit(lfc_pkg::OFF_SLOW_STOP_TASK);
  assign t_cal   = task_hit(lfc_pkg::OFF_CAL_TASK);
  assign t_go    = task_hit(lfc_pkg::OFF_CT_GO_TASK);
  assign t_halt  = task_hit(lfc_pkg::OFF_CT_HALT_TASK);

  always_comb begin
    rdata  = 32'h0000_0000;
    mapped = 1'b1;
    if (PADDR == lfc_pkg::OFF_SLOW_START_TASK || PADDR == lfc_pkg::OFF_SLOW_STOP_TASK ||
        PADDR == lfc_pkg::OFF_CAL_TASK || PADDR == lfc_pkg::OFF_CT_GO_TASK ||
        PADDR == lfc_pkg::OFF_CT_HALT_TASK) begin
      rdata = 32'h0000_0000;
    end else if (PADDR == lfc_pkg::OFF_SLOW_STARTED_EVENT) begin
      rdata[0] = ev_started_r;
    end else if (PADDR == lfc_pkg::OFF_CAL_DONE_EVENT) begin
      rdata[0] = ev_done_r;
    end else if (PADDR == lfc_pkg::OFF_CT_EXPIRED_EVENT) begin
      rdata[0] = ev_expired_r;
    end else if (PADDR == lfc_pkg::OFF_CT_GO_ACK) begin
      rdata[0] = ev_go_ack_r;
    end else if (PADDR == lfc_pkg::OFF_CT_HALT_ACK) begin
      rdata[0] = ev_halt_ack_r;
    end else if (PADDR == lfc_pkg::OFF_SLOW_RUN_STATUS) begin
      rdata[0] = run_r;
    end else if (PADDR == lfc_pkg::OFF_SLOW_CLOCK_STATUS) begin
      rdata[lfc_pkg::POS_SOURCE_CODE +: 2] = SLOW_CLOCK_SEL;
      rdata[lfc_pkg::POS_RUNNING]          = SLOW_RUNNING;
    end else if (PADDR == lfc_pkg::OFF_SLOW_SOURCE_COPY) begin
      rdata[lfc_pkg::POS_SOURCE_CODE +: 2] = src_copy_r.code;
      rdata[lfc_pkg::POS_FULL_SWING]       = src_copy_r.full_swing;
      rdata[lfc_pkg::POS_EXTERNAL]         = src_copy_r.external;
    end else if (PADDR == lfc_pkg::OFF_SLOW_SOURCE_SELECT) begin
      rdata[lfc_pkg::POS_SOURCE_CODE +: 2] = src_sel_r.code;
      rdata[lfc_pkg::POS_FULL_SWING]       = src_sel_r.full_swing;
      rdata[lfc_pkg::POS_EXTERNAL]         = src_sel_r.external;
    end else if (PADDR == lfc_pkg::OFF_SLOW_SETTLE_TIME) begin
      rdata[3:0] = settle_r;
    end else if (PADDR == lfc_pkg::OFF_CT_INTERVAL) begin
      rdata[6:0] = ct_iv_r;
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= PSEL && PENABLE && !PREADY;
      PSLVERR <= PSEL && PENABLE && !PREADY && !mapped;
      if (PSEL && PENABLE && !PREADY && !PWRITE) begin
        PRDATA <= rdata;
      end
    end
  end

  // configuration registers; source select is frozen while the clock runs
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      src_sel_r <= '{external: 1'b0, full_swing: 1'b0, code: lfc_pkg::SRC_RC};
      settle_r  <= lfc_pkg::RST_SETTLE_TIME;
      ct_iv_r   <= lfc_pkg::RST_CT_INTERVAL;
    end else if (wr && !PSLVERR) begin
      if (PADDR == lfc_pkg::OFF_SLOW_SOURCE_SELECT && !run_r) begin
        src_sel_r.code       <= PWDATA[lfc_pkg::POS_SOURCE_CODE +: 2];
        src_sel_r.full_swing <= PWDATA[lfc_pkg::POS_FULL_SWING];
        src_sel_r.external   <= PWDATA[lfc_pkg::POS_EXTERNAL];
      end else if (PADDR == lfc_pkg::OFF_SLOW_SETTLE_TIME) begin
        settle_r <= PWDATA[3:0];
      end else if (PADDR == lfc_pkg::OFF_CT_INTERVAL) begin
        ct_iv_r <= PWDATA[6:0];
      end
    end
  end

  // reserved code 3 falls back to RC, the safe default
  assign start_code = (src_sel_r.code == 2'h3) ? lfc_pkg::SRC_RC : src_sel_r.code;

  assign started_set = !SYSTEM_OFF && !t_stop && (
      (state_r == lfc_pkg::ST_WAIT && src_copy_r.code == lfc_pkg::SRC_RC && RC_READY) ||
      (state_r == lfc_pkg::ST_WAIT && src_copy_r.code == lfc_pkg::SRC_SYNTH &&
       FAST_CLOCK_READY) ||
      (state_r == lfc_pkg::ST_XSETTLE && settled));

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r         <= lfc_pkg::ST_OFF;
      src_copy_r      <= '{external: 1'b0, full_swing: 1'b0, code: lfc_pkg::SRC_RC};
      run_r           <= 1'b0;
      RC_OSC_EN       <= 1'b0;
      XTAL_OSC_EN     <= 1'b0;
      XTAL_EXTERNAL   <= 1'b0;
      XTAL_FULL_SWING <= 1'b0;
      SYNTH_EN        <= 1'b0;
      SLOW_RUNNING    <= 1'b0;
      SLOW_CLOCK_SEL  <= lfc_pkg::SRC_RC;
    end else if (SYSTEM_OFF || (t_stop && state_r != lfc_pkg::ST_OFF)) begin
      state_r      <= lfc_pkg::ST_OFF;
      run_r        <= 1'b0;
      RC_OSC_EN    <= 1'b0;
      XTAL_OSC_EN  <= 1'b0;
      SYNTH_EN     <= 1'b0;
      SLOW_RUNNING <= 1'b0;
    end else begin
      case (state_r)
        lfc_pkg::ST_OFF: begin
          if (t_start) begin
            state_r         <= lfc_pkg::ST_WAIT;
            run_r           <= 1'b1;
            src_copy_r      <= '{external: src_sel_r.external,
                                 full_swing: src_sel_r.full_swing, code: start_code};
            RC_OSC_EN       <= (start_code != lfc_pkg::SRC_SYNTH);
            XTAL_OSC_EN     <= (start_code == lfc_pkg::SRC_XTAL);
            XTAL_EXTERNAL   <= (start_code == lfc_pkg::SRC_XTAL) && src_sel_r.external;
            XTAL_FULL_SWING <= (start_code == lfc_pkg::SRC_XTAL) && src_sel_r.external &&
                               src_sel_r.full_swing;
            SYNTH_EN        <= (start_code == lfc_pkg::SRC_SYNTH);
          end
        end
        lfc_pkg::ST_WAIT: begin
          if (started_set) begin
            state_r        <= lfc_pkg::ST_RUN;
            SLOW_RUNNING   <= 1'b1;
            SLOW_CLOCK_SEL <= src_copy_r.code;
          end else if (src_copy_r.code == lfc_pkg::SRC_XTAL && RC_READY) begin
            state_r        <= lfc_pkg::ST_XSETTLE;
            SLOW_RUNNING   <= 1'b1;
            SLOW_CLOCK_SEL <= lfc_pkg::SRC_RC;
          end
        end
        lfc_pkg::ST_XSETTLE: begin
          if (settled) begin
            state_r        <= lfc_pkg::ST_RUN;
            SLOW_CLOCK_SEL <= lfc_pkg::SRC_XTAL;
            RC_OSC_EN      <= cal_busy_r || cal_accept; // rc kept alive until calibration ends
          end
        end
        default: begin
          if (!cal_busy_r && SLOW_CLOCK_SEL != lfc_pkg::SRC_RC) begin
            RC_OSC_EN <= 1'b0;
          end
        end
      endcase
    end
  end

  lfc_settle #(
    .UNIT_CYCLES (SETTLE_CYCLES),
    .CODE_W      (4)
  ) u_settle (
    .clk         (CLOCK),
    .rst_n       (RESET_N),
    .enable      (XTAL_OSC_EN),
    .ready       (XTAL_READY),
    .settle_code (settle_r),
    .settled     (settled)
  );

  // calibration only accepted with the rc oscillator up
  assign cal_accept = t_cal && !cal_busy_r && RC_OSC_EN && RC_READY && !SYSTEM_OFF;
  assign done_set   = cal_busy_r && CAL_DONE;

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      cal_busy_r     <= 1'b0;
      CAL_START      <= 1'b0;
      FAST_CLOCK_REQ <= 1'b0;
    end else begin
      CAL_START <= cal_accept;
      if (SYSTEM_OFF || done_set) begin
        cal_busy_r <= 1'b0;
      end else if (cal_accept) begin
        cal_busy_r <= 1'b1;
      end
      FAST_CLOCK_REQ <= !SYSTEM_OFF && (SYNTH_EN || cal_busy_r);
    end
  end

  lfc_cal_timer #(
    .TICK_CYCLES (CT_TICK_CYCLES),
    .IV_W        (7)
  ) u_ct (
    .clk      (CLOCK),
    .rst_n    (RESET_N),
    .go       (t_go),
    .halt     (t_halt),
    .interval (ct_iv_r),
    .go_ack   (ct_go_ack),
    .halt_ack (ct_halt_ack),
    .expired  (ct_expired),
    .running  (ct_running)
  );

  // sticky events: a set in the clearing cycle wins
  function automatic logic ev_next(input logic cur, input logic set, input logic [11:0] off);
    ev_next = set || (cur && !(wr && PADDR == off && !PWDATA[0]));
  endfunction : ev_next

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      ev_started_r  <= 1'b0;
      ev_done_r     <= 1'b0;
      ev_expired_r  <= 1'b0;
      ev_go_ack_r   <= 1'b0;
      ev_halt_ack_r <= 1'b0;
    end else begin
      ev_started_r  <= ev_next(ev_started_r, started_set, lfc_pkg::OFF_SLOW_STARTED_EVENT);
      ev_done_r     <= ev_next(ev_done_r, done_set, lfc_pkg::OFF_CAL_DONE_EVENT);
      ev_expired_r  <= ev_next(ev_expired_r, ct_expired, lfc_pkg::OFF_CT_EXPIRED_EVENT);
      ev_go_ack_r   <= ev_next(ev_go_ack_r, ct_go_ack, lfc_pkg::OFF_CT_GO_ACK);
      ev_halt_ack_r <= ev_next(ev_halt_ack_r, ct_halt_ack, lfc_pkg::OFF_CT_HALT_ACK);
    end
  end

endmodule : lfc_ctrl

// [design/lfc_pkg.sv]
/*
  lfc_pkg: shared constants and types for the slow clock controller.
  Assumes a 50 MHz system clock and an APB register bus with byte addressing.
*/
package lfc_pkg;

  localparam int CLK_MHZ = 50;

  // register byte offsets
  localparam logic [11:0] OFF_SLOW_START_TASK     = 12'h008;
  localparam logic [11:0] OFF_SLOW_STOP_TASK      = 12'h00C;
  localparam logic [11:0] OFF_CAL_TASK            = 12'h010;
  localparam logic [11:0] OFF_CT_GO_TASK          = 12'h014;
  localparam logic [11:0] OFF_CT_HALT_TASK        = 12'h018;
  localparam logic [11:0] OFF_SLOW_STARTED_EVENT  = 12'h104;
  localparam logic [11:0] OFF_CAL_DONE_EVENT      = 12'h10C;
  localparam logic [11:0] OFF_CT_EXPIRED_EVENT    = 12'h110;
  localparam logic [11:0] OFF_CT_GO_ACK           = 12'h128;
  localparam logic [11:0] OFF_CT_HALT_ACK         = 12'h12C;
  localparam logic [11:0] OFF_SLOW_RUN_STATUS     = 12'h414;
  localparam logic [11:0] OFF_SLOW_CLOCK_STATUS   = 12'h418;
  localparam logic [11:0] OFF_SLOW_SOURCE_COPY    = 12'h41C;
  localparam logic [11:0] OFF_SLOW_SOURCE_SELECT  = 12'h518;
  localparam logic [11:0] OFF_SLOW_SETTLE_TIME    = 12'h52C;
  localparam logic [11:0] OFF_CT_INTERVAL         = 12'h538;

  // field positions
  localparam int POS_SOURCE_CODE = 0;
  localparam int POS_FULL_SWING  = 16;
  localparam int POS_EXTERNAL    = 17;
  localparam int POS_RUNNING     = 16;

  // source codes
  localparam logic [1:0] SRC_RC    = 2'h0;
  localparam logic [1:0] SRC_XTAL  = 2'h1;
  localparam logic [1:0] SRC_SYNTH = 2'h2;

  // reset values
  localparam logic [3:0] RST_SETTLE_TIME = 4'h4;
  localparam logic [6:0] RST_CT_INTERVAL = 7'h00;

  // one settle unit is one slow clock period, least time rounds up
  localparam int SETTLE_UNIT_NS     = 30518;
  localparam int SETTLE_UNIT_CYCLES = (SETTLE_UNIT_NS * CLK_MHZ + 999) / 1000;
  // calibration timer tick
  localparam int CT_TICK_US     = 250000;
  localparam int CT_TICK_CYCLES = CT_TICK_US * CLK_MHZ;

  typedef struct packed {
    logic       external;
    logic       full_swing;
    logic [1:0] code;
  } lfc_src_t;

  typedef enum logic [1:0] {
    ST_OFF     = 2'b00,
    ST_WAIT    = 2'b01,
    ST_XSETTLE = 2'b10,
    ST_RUN     = 2'b11
  } lfc_state_t;

endpackage : lfc_pkg

// [design/lfc_settle.sv]
/*
  lfc_settle: crystal settle counter.
  Assumes ready comes from the crystal oscillator, synchronous to clk.
*/
`timescale 1ns/1ps
module lfc_settle #(
  parameter int UNIT_CYCLES = lfc_pkg::SETTLE_UNIT_CYCLES,
  parameter int CODE_W      = 4
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              enable,
  input  wire logic              ready,
  input  wire logic [CODE_W-1:0] settle_code,
  output logic                   settled
);
  logic [$clog2(UNIT_CYCLES+1)-1:0] pre_r;
  logic [CODE_W:0]                  units_r;
  logic                             unit_tick;

  assign unit_tick = (pre_r == UNIT_CYCLES[$clog2(UNIT_CYCLES+1)-1:0] - 1'b1);

  // restart whenever the crystal drops out, a glitch must not shorten settling
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r   <= '0;
      units_r <= '0;
    end else if (!enable || !ready) begin
      pre_r   <= '0;
      units_r <= '0;
    end else if (!settled) begin
      pre_r <= unit_tick ? '0 : pre_r + 1'b1;
      if (unit_tick) begin
        units_r <= units_r + 1'b1;
      end
    end
  end

  assign settled = enable && ready && (units_r > {1'b0, settle_code});

endmodule : lfc_settle
